// ### rtl/stce_exec.sv
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module stce_exec
    import stce_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic INSTR_VALID,
    input wire logic [31:0] INSTR_WORD,
    input wire logic [31:0] INSTR_PC,
    input wire logic COND_PASS,
    input wire logic [31:0] BASE_VAL,
    input wire logic [31:0] SOURCE_VAL,
    input wire logic [31:0] CUR_STATUS,
    output logic INSTR_READY,
    output logic MEM_REQ,
    output logic MEM_WRITE,
    output logic MEM_BYTE,
    output logic MEM_LOCK,
    output logic [31:0] MEM_ADDR,
    output logic [31:0] MEM_WDATA,
    input wire logic [31:0] MEM_RDATA,
    input wire logic MEM_READY,
    input wire logic MEM_ABORT,
    output logic RF_WE,
    output logic [3:0] RF_WADDR,
    output logic [31:0] RF_WDATA,
    output logic PC_LOAD,
    output logic [31:0] PC_VAL,
    output logic STATUS_LOAD,
    output logic [31:0] STATUS_VAL,
    input wire logic IRQ_REQ,
    output logic IRQ_TAKE,
    output logic CP_VALID,
    output logic [31:0] CP_WORD
);

    stce_state_s cur_ff;
    stce_state_s nxt_cur;
    stce_dec_s dec;
    logic accept;
    logic mode32;
    logic apb_done;
    logic [31:0] svc_ret;
    logic [31:0] link26;
    logic [31:0] rd_val;

    stce_decode u_decode (
        .instr(INSTR_WORD),
        .dec(dec)
    );

    // aligned load: byte zero-extended, word rotated by low address bits
    function automatic logic [31:0] load_align(input logic [31:0] d, input logic [1:0] a, input logic b);
        logic [31:0] r;
        r = '0;
        unique case (a)
            2'd0: r = d;
            2'd1: r = {d[7:0], d[31:8]};
            2'd2: r = {d[15:0], d[31:16]};
            2'd3: r = {d[23:0], d[31:24]};
        endcase
        if (b) begin
            r = {24'h00_0000, r[7:0]};
        end
        return r;
    endfunction : load_align

    // entry status: interrupts off, mode switched to supervisor or abort
    function automatic logic [31:0] entry_status(input logic [31:0] s, input logic [4:0] m);
        logic [31:0] r;
        r = s;
        r[STCE_PSR_I_BIT] = 1'b1;
        r[4:0] = m;
        return r;
    endfunction : entry_status

    // helper values
    assign mode32 = cur_ff.ctrl[STCE_CTRL_MODE32_BIT];
    assign accept = INSTR_VALID & cur_ff.instr_ready;
    assign svc_ret = INSTR_PC + STCE_RET_SVC_OFS;
    assign link26 = {CUR_STATUS[31:28], CUR_STATUS[7:6], svc_ret[25:2], CUR_STATUS[1:0]};
    assign rd_val = load_align(MEM_RDATA, cur_ff.mem.addr[1:0], cur_ff.mem.byte_sel);
    assign apb_done = PSEL & PENABLE & cur_ff.pready;

    // next-state logic for the whole block
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rf_we = 1'b0;
        nxt_cur.pc_load = 1'b0;
        nxt_cur.st_load = 1'b0;
        nxt_cur.irq_take = 1'b0;
        nxt_cur.cp_valid = 1'b0;
        unique case (cur_ff.state)
            ST_IDLE: begin
                if (accept) begin
                    if (COND_PASS) begin
                        unique case (dec.cls)
                            CL_SWAP: begin
                                nxt_cur.state = ST_SWP_RD;
                                nxt_cur.mem.req = 1'b1;
                                nxt_cur.mem.write = 1'b0;
                                nxt_cur.mem.lock = 1'b1;
                                nxt_cur.mem.byte_sel = dec.byte_sel;
                                nxt_cur.mem.addr = BASE_VAL;
                                nxt_cur.src_val = SOURCE_VAL;
                                nxt_cur.dest_idx = dec.dest_idx;
                                nxt_cur.instr_pc = INSTR_PC;
                            end
                            CL_SVC_CALL: begin
                                nxt_cur.pc_load = 1'b1;
                                nxt_cur.pc_val = STCE_VEC_SVC;
                                nxt_cur.st_load = 1'b1;
                                if (mode32) begin
                                    nxt_cur.svc_link = svc_ret;
                                    nxt_cur.svc_saved = CUR_STATUS;
                                    nxt_cur.st_val = entry_status(CUR_STATUS, STCE_MODE_SVC32);
                                end else begin
                                    nxt_cur.svc_link = link26;
                                    nxt_cur.st_val = entry_status(CUR_STATUS, STCE_MODE_SVC26);
                                end
                            end
                            CL_CP_DATA: begin
                                nxt_cur.cp_valid = 1'b1;
                                nxt_cur.cp_word = INSTR_WORD;
                            end
                            CL_RET_FLAGS: begin
                                nxt_cur.pc_load = 1'b1;
                                nxt_cur.st_load = 1'b1;
                                if (mode32) begin
                                    nxt_cur.pc_val = cur_ff.svc_link;
                                    nxt_cur.st_val = cur_ff.svc_saved;
                                end else begin
                                    nxt_cur.pc_val = {6'h00, cur_ff.svc_link[25:2], 2'h0};
                                    nxt_cur.st_val = {cur_ff.svc_link[31:28], CUR_STATUS[27:8],
                                        cur_ff.svc_link[27:26], CUR_STATUS[5:2], cur_ff.svc_link[1:0]};
                                end
                            end
                            CL_NONE: begin
                            end
                        endcase
                    end
                end else if (IRQ_REQ && cur_ff.ctrl[STCE_CTRL_IRQ_EN_BIT]) begin
                    nxt_cur.irq_take = 1'b1;
                end
            end
            ST_SWP_RD: begin
                if (MEM_READY) begin
                    if (MEM_ABORT) begin
                        nxt_cur.state = ST_IDLE;
                        nxt_cur.mem.req = 1'b0;
                        nxt_cur.mem.lock = 1'b0;
                        nxt_cur.rd_abt = 1'b1;
                    end else begin
                        nxt_cur.state = ST_SWP_WR;
                        nxt_cur.rd_data = rd_val;
                        nxt_cur.mem.write = 1'b1;
                        nxt_cur.mem.wdata = cur_ff.mem.byte_sel ? {4{cur_ff.src_val[7:0]}} : cur_ff.src_val;
                    end
                end
            end
            ST_SWP_WR: begin
                if (MEM_READY) begin
                    nxt_cur.state = ST_IDLE;
                    nxt_cur.mem.req = 1'b0;
                    nxt_cur.mem.write = 1'b0;
                    nxt_cur.mem.lock = 1'b0;
                    if (MEM_ABORT) begin
                        nxt_cur.wr_abt = 1'b1;
                    end else begin
                        nxt_cur.rf_we = 1'b1;
                        nxt_cur.rf_waddr = cur_ff.dest_idx;
                        nxt_cur.rf_wdata = cur_ff.rd_data;
                        nxt_cur.swap_cnt = cur_ff.swap_cnt + 32'h0000_0001;
                    end
                end
            end
            default: begin
                nxt_cur.state = ST_IDLE;
            end
        endcase

        // data abort trap once the swap has ended
        if (cur_ff.state != ST_IDLE && MEM_READY && MEM_ABORT) begin
            nxt_cur.pc_load = 1'b1;
            nxt_cur.pc_val = STCE_VEC_DABT;
            nxt_cur.st_load = 1'b1;
            nxt_cur.st_val = entry_status(CUR_STATUS, mode32 ? STCE_MODE_ABT32 : STCE_MODE_SVC26);
            nxt_cur.abt_link = cur_ff.instr_pc + STCE_RET_DABT_OFS;
        end
        nxt_cur.instr_ready = (nxt_cur.state == ST_IDLE);

        // apb slave: two wait states, answer registered
        nxt_cur.pready = 1'b0;
        nxt_cur.pslverr = 1'b0;
        if (PSEL && PENABLE && !cur_ff.pready) begin
            if (cur_ff.apb_wait == STCE_APB_WAIT) begin
                nxt_cur.pready = 1'b1;
                nxt_cur.apb_wait = 2'h0;
                nxt_cur.prdata = '0;
                unique case (PADDR)
                    STCE_OFS_CTRL: nxt_cur.prdata = cur_ff.ctrl;
                    STCE_OFS_STATUS: begin
                        nxt_cur.prdata[STCE_STAT_STATE_LSB +: 2] = cur_ff.state;
                        nxt_cur.prdata[STCE_STAT_RD_ABT_BIT] = cur_ff.rd_abt;
                        nxt_cur.prdata[STCE_STAT_WR_ABT_BIT] = cur_ff.wr_abt;
                        nxt_cur.prdata[STCE_STAT_LOCK_BIT] = cur_ff.mem.lock;
                        nxt_cur.prdata[STCE_STAT_BUSY_BIT] = !cur_ff.instr_ready;
                    end
                    STCE_OFS_SVC_LINK: nxt_cur.prdata = cur_ff.svc_link;
                    STCE_OFS_SVC_SAVED: nxt_cur.prdata = cur_ff.svc_saved;
                    STCE_OFS_ABT_LINK: nxt_cur.prdata = cur_ff.abt_link;
                    STCE_OFS_SWAP_CNT: nxt_cur.prdata = cur_ff.swap_cnt;
                    default: nxt_cur.pslverr = 1'b1;
                endcase
                if (PWRITE) begin
                    nxt_cur.prdata = '0;
                end
            end else begin
                nxt_cur.apb_wait = cur_ff.apb_wait + 2'h1;
            end
        end

        // apb writes; abort flags clear by writing one, a new abort wins
        if (apb_done && PWRITE && !cur_ff.pslverr) begin
            unique case (PADDR)
                STCE_OFS_CTRL: nxt_cur.ctrl = PWDATA & STCE_CTRL_MASK;
                STCE_OFS_STATUS: begin
                    if (PWDATA[STCE_STAT_RD_ABT_BIT] && !(cur_ff.state == ST_SWP_RD && MEM_READY && MEM_ABORT)) begin
                        nxt_cur.rd_abt = 1'b0;
                    end
                    if (PWDATA[STCE_STAT_WR_ABT_BIT] && !(cur_ff.state == ST_SWP_WR && MEM_READY && MEM_ABORT)) begin
                        nxt_cur.wr_abt = 1'b0;
                    end
                end
                STCE_OFS_SVC_LINK: begin
                    if (!nxt_cur.pc_load || cur_ff.state != ST_IDLE) begin
                        nxt_cur.svc_link = PWDATA;
                    end
                end
                STCE_OFS_SVC_SAVED: begin
                    if (!nxt_cur.pc_load || cur_ff.state != ST_IDLE) begin
                        nxt_cur.svc_saved = PWDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cur_ff <= '0;
            cur_ff.ctrl <= STCE_CTRL_RST;
            cur_ff.instr_ready <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // outputs straight from the state register
    assign PRDATA = cur_ff.prdata;
    assign PREADY = cur_ff.pready;
    assign PSLVERR = cur_ff.pslverr;
    assign INSTR_READY = cur_ff.instr_ready;
    assign MEM_REQ = cur_ff.mem.req;
    assign MEM_WRITE = cur_ff.mem.write;
    assign MEM_BYTE = cur_ff.mem.byte_sel;
    assign MEM_LOCK = cur_ff.mem.lock;
    assign MEM_ADDR = cur_ff.mem.addr;
    assign MEM_WDATA = cur_ff.mem.wdata;
    assign RF_WE = cur_ff.rf_we;
    assign RF_WADDR = cur_ff.rf_waddr;
    assign RF_WDATA = cur_ff.rf_wdata;
    assign PC_LOAD = cur_ff.pc_load;
    assign PC_VAL = cur_ff.pc_val;
    assign STATUS_LOAD = cur_ff.st_load;
    assign STATUS_VAL = cur_ff.st_val;
    assign IRQ_TAKE = cur_ff.irq_take;
    assign CP_VALID = cur_ff.cp_valid;
    assign CP_WORD = cur_ff.cp_word;

endmodule : stce_exec

// ### pkg/stce_pkg.sv
package stce_pkg;

    // register byte offsets
    localparam logic [11:0] STCE_OFS_CTRL = 12'h000;
    localparam logic [11:0] STCE_OFS_STATUS = 12'h004;
    localparam logic [11:0] STCE_OFS_SVC_LINK = 12'h008;
    localparam logic [11:0] STCE_OFS_SVC_SAVED = 12'h00C;
    localparam logic [11:0] STCE_OFS_ABT_LINK = 12'h010;
    localparam logic [11:0] STCE_OFS_SWAP_CNT = 12'h014;

    // control fields and reset value
    localparam int STCE_CTRL_MODE32_BIT = 0;
    localparam int STCE_CTRL_IRQ_EN_BIT = 1;
    localparam logic [31:0] STCE_CTRL_MASK = 32'h0000_0003;
    localparam logic [31:0] STCE_CTRL_RST = 32'h0000_0003;

    // status fields
    localparam int STCE_STAT_STATE_LSB = 0;
    localparam int STCE_STAT_RD_ABT_BIT = 4;
    localparam int STCE_STAT_WR_ABT_BIT = 5;
    localparam int STCE_STAT_LOCK_BIT = 8;
    localparam int STCE_STAT_BUSY_BIT = 9;

    // trap vectors and return offsets
    localparam logic [31:0] STCE_VEC_SVC = 32'h0000_0008;
    localparam logic [31:0] STCE_VEC_DABT = 32'h0000_0010;
    localparam logic [31:0] STCE_RET_SVC_OFS = 32'h0000_0004;
    localparam logic [31:0] STCE_RET_DABT_OFS = 32'h0000_0008;

    // status word layout and mode codes
    localparam int STCE_PSR_I_BIT = 7;
    localparam logic [4:0] STCE_MODE_SVC32 = 5'h13;
    localparam logic [4:0] STCE_MODE_ABT32 = 5'h17;
    localparam logic [4:0] STCE_MODE_SVC26 = 5'h03;

    // instruction encodings, condition field excluded
    localparam logic [27:0] STCE_SWAP_MASK = 28'hFB0_0FF0;
    localparam logic [27:0] STCE_SWAP_MATCH = 28'h100_0090;
    localparam logic [27:0] STCE_SVC_MASK = 28'hF00_0000;
    localparam logic [27:0] STCE_SVC_MATCH = 28'hF00_0000;
    localparam logic [27:0] STCE_CPD_MASK = 28'hF00_0010;
    localparam logic [27:0] STCE_CPD_MATCH = 28'hE00_0000;
    localparam logic [27:0] STCE_RETF_MATCH = 28'h1B0_F00E;
    localparam int STCE_BYTE_BIT = 22;
    localparam int STCE_SVC_COMMENT_W = 24;

    // apb wait count reached before pready is set
    localparam logic [1:0] STCE_APB_WAIT = 2'h1;

    typedef enum logic [1:0] {ST_IDLE, ST_SWP_RD, ST_SWP_WR} stce_state_e;

    typedef enum logic [2:0] {CL_NONE, CL_SWAP, CL_SVC_CALL, CL_CP_DATA, CL_RET_FLAGS} stce_class_e;

    typedef struct packed {
        stce_class_e cls;
        logic byte_sel;
        logic [3:0] base_idx;
        logic [3:0] dest_idx;
        logic [3:0] src_idx;
        logic [3:0] cp_num;
    } stce_dec_s;

    typedef struct packed {
        logic req;
        logic write;
        logic byte_sel;
        logic lock;
        logic [31:0] addr;
        logic [31:0] wdata;
    } stce_mem_s;

    typedef struct packed {
        stce_state_e state;
        stce_mem_s mem;
        logic [31:0] src_val;
        logic [31:0] rd_data;
        logic [3:0] dest_idx;
        logic [31:0] instr_pc;
        logic instr_ready;
        logic rf_we;
        logic [3:0] rf_waddr;
        logic [31:0] rf_wdata;
        logic pc_load;
        logic [31:0] pc_val;
        logic st_load;
        logic [31:0] st_val;
        logic irq_take;
        logic cp_valid;
        logic [31:0] cp_word;
        logic [31:0] ctrl;
        logic rd_abt;
        logic wr_abt;
        logic [31:0] svc_link;
        logic [31:0] svc_saved;
        logic [31:0] abt_link;
        logic [31:0] swap_cnt;
        logic [1:0] apb_wait;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } stce_state_s;

endpackage : stce_pkg

// ### rtl/stce_decode.sv
`timescale 1ns/1ps
module stce_decode
    import stce_pkg::*;
(
    input wire logic [31:0] instr,
    output stce_dec_s dec
);

    // classify by fixed bits; low comment bits and coprocessor bits never looked at
    always_comb begin
        dec = '0;
        dec.byte_sel = instr[STCE_BYTE_BIT];
        dec.base_idx = instr[19:16];
        dec.dest_idx = instr[15:12];
        dec.src_idx = instr[3:0];
        dec.cp_num = instr[11:8];
        if ((instr[27:0] & STCE_SWAP_MASK) == STCE_SWAP_MATCH) begin
            dec.cls = CL_SWAP;
        end else if ((instr[27:0] & STCE_SVC_MASK) == STCE_SVC_MATCH) begin
            dec.cls = CL_SVC_CALL;
        end else if ((instr[27:0] & STCE_CPD_MASK) == STCE_CPD_MATCH) begin
            dec.cls = CL_CP_DATA;
        end else if (instr[27:0] == STCE_RETF_MATCH) begin
            dec.cls = CL_RET_FLAGS;
        end else begin
            dec.cls = CL_NONE;
        end
    end

endmodule : stce_decode

// ### verification/stce_monitor.sv
`timescale 1ns/1ps
module stce_monitor
    import stce_pkg::*;
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic INSTR_VALID,
    input wire logic INSTR_READY,
    input wire logic [31:0] INSTR_WORD,
    input wire logic COND_PASS,
    input wire logic [31:0] BASE_VAL,
    input wire logic MEM_REQ,
    input wire logic MEM_WRITE,
    input wire logic MEM_LOCK,
    input wire logic [31:0] MEM_ADDR,
    input wire logic MEM_READY,
    input wire logic MEM_ABORT,
    input wire logic RF_WE,
    input wire logic PC_LOAD,
    input wire logic [31:0] PC_VAL,
    input wire logic STATUS_LOAD,
    input wire logic IRQ_TAKE,
    input wire logic CP_VALID,
    input wire logic [31:0] CP_WORD
);
    // accepted instruction and its class
    wire acc = INSTR_VALID && INSTR_READY;
    wire run = acc && COND_PASS;
    wire atomic_swap_instr = run && ((INSTR_WORD[27:0] & STCE_SWAP_MASK) == STCE_SWAP_MATCH);
    wire svc = run && ((INSTR_WORD[27:0] & STCE_SVC_MASK) == STCE_SVC_MATCH);
    wire cpd = run && ((INSTR_WORD[27:0] & STCE_CPD_MASK) == STCE_CPD_MATCH);
    wire rd_end = MEM_REQ && !MEM_WRITE && MEM_READY;

    default clocking mon_cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    lock_span_a: assert property (MEM_REQ |-> MEM_LOCK)
        else $error("request unlocked");
    swap_start_a: assert property (atomic_swap_instr |=> MEM_REQ && !MEM_WRITE && MEM_LOCK
        && MEM_ADDR == $past(BASE_VAL)) else $error("bad swap read");
    req_hold_a: assert property (MEM_REQ && !MEM_READY |=> MEM_REQ
        && $stable(MEM_ADDR) && $stable(MEM_WRITE)) else $error("request moved");
    read_write_a: assert property (rd_end && !MEM_ABORT |=> MEM_REQ && MEM_WRITE
        && MEM_LOCK && $stable(MEM_ADDR)) else $error("no swap write");
    read_abort_a: assert property (rd_end && MEM_ABORT |=> !MEM_REQ && !MEM_LOCK
        && PC_LOAD && !RF_WE && PC_VAL == STCE_VEC_DABT) else $error("bad read abort");
    write_end_a: assert property (MEM_REQ && MEM_WRITE && MEM_READY |=> !MEM_LOCK && !MEM_REQ
        && INSTR_READY && RF_WE == !$past(MEM_ABORT) && PC_LOAD == $past(MEM_ABORT)) else $error("bad swap end");
    no_irq_swap_a: assert property (MEM_LOCK |-> !IRQ_TAKE ##1 !IRQ_TAKE)
        else $error("irq in swap");
    svc_entry_a: assert property (svc |=> PC_LOAD && STATUS_LOAD && PC_VAL == STCE_VEC_SVC)
        else $error("bad call entry");
    cp_issue_a: assert property (cpd |=> CP_VALID && INSTR_READY && CP_WORD == $past(INSTR_WORD))
        else $error("bad cp issue");
    cond_skip_a: assert property (acc && !COND_PASS |=> !PC_LOAD && !CP_VALID && !MEM_REQ && !RF_WE)
        else $error("skip had effect");
endmodule : stce_monitor

// ### verification/stce_partner.sv
`timescale 1ns/1ps
module stce_mem_model (
    input wire logic CLK,
    input wire logic [1:0] slow,
    input wire logic abt_rd,
    input wire logic abt_wr,
    input wire logic req,
    input wire logic write,
    input wire logic byte_sel,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata,
    output logic ready,
    output logic abort
);
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0000_0000;
    logic [1:0] cnt = 2'h0;
    initial for (int i = 0; i < 16; i++) mem[i] = 32'h1111_1111 * i;
    initial ready = 1'b0;
    // answers after slow waits
    always @(posedge CLK) begin
        ready <= 1'b0;
        abort <= 1'b0;
        rdata <= ~last;
        if (req && !ready) begin
            cnt <= cnt + 2'h1;
            if (cnt == slow) begin
                cnt <= 2'h0;
                ready <= 1'b1;
                abort <= write ? abt_wr : abt_rd;
                if (!write) begin
                    rdata <= mem[addr[5:2]];
                    last <= mem[addr[5:2]];
                end else if (!abt_wr && byte_sel) begin
                    mem[addr[5:2]][8*addr[1:0] +: 8] <= wdata[8*addr[1:0] +: 8];
                end else if (!abt_wr) begin
                    mem[addr[5:2]] <= wdata;
                end
            end
        end
    end
endmodule : stce_mem_model

module stce_cop_model #(
    parameter logic [3:0] OWN_NUM = 4'h0
) (
    input wire logic CLK,
    input wire logic valid,
    input wire logic [31:0] word,
    output int hits,
    output logic [3:0] dest
);
    initial hits = 0;
    // own number only; result to dest
    always @(posedge CLK) begin
        if (valid && word[11:8] == OWN_NUM) begin
            hits <= hits + 1;
            dest <= word[15:12];
        end
    end
endmodule : stce_cop_model

// ### verification/stce_exec_tb.sv
`timescale 1ns/1ps
module stce_exec_tb;
    import stce_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic instr_valid = 1'b0, cond_pass = 1'b0, irq_req = 1'b0, instr_ready, irq_take;
    logic [31:0] instr_word = 32'h0000_0000, instr_pc = 32'h0000_0100, base_val = 32'h0000_0000;
    logic [31:0] source_val = 32'h0000_0000, cur_status = 32'h0000_0010;
    logic mem_req, mem_write, mem_byte, mem_lock, mem_ready, mem_abort, rf_we, pc_load, status_load, cp_valid;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, rf_wdata, pc_val, status_val, cp_word, pc_v, st_v, rf_v, cp_v;
    logic [3:0] rf_waddr, rf_a, dest4;
    logic [1:0] slow = 2'h0;
    logic abt_rd = 1'b0, abt_wr = 1'b0;
    int num_errors = 0, n_compared = 0, got_pc, got_rf, got_cp, got_wr, got_irq, hits4, hits5;
    logic [31:0] sw_w [3] = '{32'hE100_3091, 32'hE100_1091, 32'hE140_2093};
    logic [31:0] sw_b [3] = '{32'h0000_0020, 32'h0000_0024, 32'h0000_0029};
    logic [31:0] sw_s [3] = '{32'hCAFE_0001, 32'h1234_5678, 32'h0000_00C5};
    logic [31:0] sw_old [3] = '{32'h8888_8888, 32'h9999_9999, 32'h0000_00AA};
    logic [31:0] sw_new [3] = '{32'hCAFE_0001, 32'h1234_5678, 32'hAAAA_C5AA};
    logic [3:0] sw_d [3] = '{4'h3, 4'h1, 4'h2};
    logic [31:0] cl_w [3] = '{32'hE100_3091, 32'hEF00_0000, 32'hEE12_3405};
    logic [31:0] cp_w [3] = '{32'hEE12_3405, 32'hEEED_C50A, 32'hEE12_3415};
    int cp_n [3] = '{1, 1, 0};

    always #20 clk = ~clk;

    stce_exec i_dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .INSTR_VALID(instr_valid),
        .INSTR_WORD(instr_word), .INSTR_PC(instr_pc), .COND_PASS(cond_pass), .BASE_VAL(base_val),
        .SOURCE_VAL(source_val), .CUR_STATUS(cur_status), .INSTR_READY(instr_ready), .MEM_REQ(mem_req),
        .MEM_WRITE(mem_write), .MEM_BYTE(mem_byte), .MEM_LOCK(mem_lock), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .MEM_RDATA(mem_rdata), .MEM_READY(mem_ready), .MEM_ABORT(mem_abort), .RF_WE(rf_we), .RF_WADDR(rf_waddr),
        .RF_WDATA(rf_wdata), .PC_LOAD(pc_load), .PC_VAL(pc_val), .STATUS_LOAD(status_load), .STATUS_VAL(status_val),
        .IRQ_REQ(irq_req), .IRQ_TAKE(irq_take), .CP_VALID(cp_valid), .CP_WORD(cp_word));
    stce_mem_model i_mem (.CLK(clk), .slow(slow), .abt_rd(abt_rd), .abt_wr(abt_wr), .req(mem_req), .write(mem_write),
        .byte_sel(mem_byte), .addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata), .ready(mem_ready), .abort(mem_abort));
    stce_cop_model #(.OWN_NUM(4'h4)) i_cop4 (.CLK(clk), .valid(cp_valid), .word(cp_word), .hits(hits4), .dest(dest4));
    stce_cop_model #(.OWN_NUM(4'h5)) i_cop5 (.CLK(clk), .valid(cp_valid), .word(cp_word), .hits(hits5), .dest());

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // apb transfer held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd = 32'h0000_0000);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask : apb

    // record one cycle
    task automatic rec();
        @(posedge clk);
        if (pc_load === 1'b1) begin
            got_pc++;
            pc_v = pc_val;
            st_v = status_val;
        end
        if (rf_we === 1'b1) begin
            got_rf++;
            rf_v = rf_wdata;
            rf_a = rf_waddr;
        end
        if (cp_valid === 1'b1) begin
            got_cp++;
            cp_v = cp_word;
        end
        if (mem_req === 1'b1 && mem_write === 1'b1) got_wr = 1;
        if (irq_take === 1'b1) got_irq++;
    endtask : rec

    // issue one instruction, record until ready
    task automatic exec(input logic [31:0] w, input logic cp);
        int k;
        {got_pc, got_rf, got_cp, got_wr, got_irq} = '0;
        cp_v = 32'h0000_0000;
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        cond_pass <= cp;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (instr_ready !== 1'b1 && k < 40);
        instr_valid <= 1'b0;
        do begin
            rec();
            k++;
        end while ((k < 4 || instr_ready !== 1'b1) && k < 40);
        rec();
        rec();
        if (k >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask : exec

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // reset value, unmapped, read-only
        apb(1'b0, STCE_OFS_CTRL);
        chk(rd, STCE_CTRL_RST);
        apb(1'b0, 12'h018);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, STCE_OFS_SWAP_CNT, 32'hFFFF_FFFF);
        apb(1'b0, STCE_OFS_SWAP_CNT);
        chk(rd, 32'h0000_0000);
        // swaps, irq pending
        irq_req <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            base_val <= sw_b[i];
            source_val <= sw_s[i];
            slow <= 2'(i);
            exec(sw_w[i], 1'b1);
            chk(got_rf, 1);
            chk(rf_v, sw_old[i]);
            chk(rf_a, sw_d[i]);
            chk(i_mem.mem[sw_b[i][5:2]], sw_new[i]);
            chk(got_irq > 0, 1);
        end
        irq_req <= 1'b0;
        apb(1'b0, STCE_OFS_SWAP_CNT);
        chk(rd, 32'h0000_0003);
        // read abort, then write abort
        for (int m = 0; m < 2; m++) begin
            abt_rd <= (m == 0);
            abt_wr <= (m == 1);
            base_val <= 32'h0000_002C;
            exec(32'hE100_3091, 1'b1);
            chk(got_rf, 0);
            chk(got_wr, m);
            chk(pc_v, STCE_VEC_DABT);
            chk(i_mem.mem[11], 32'hBBBB_BBBB);
            apb(1'b0, STCE_OFS_ABT_LINK);
            chk(rd, 32'h0000_0108);
        end
        abt_wr <= 1'b0;
        // failed condition skips all
        for (int i = 0; i < 3; i++) begin
            exec(cl_w[i], 1'b0);
            chk(got_pc + got_rf + got_cp + got_wr, 0);
        end
        // call, comment field extremes
        cur_status <= 32'hA000_0010;
        instr_pc <= 32'h0000_0200;
        for (int i = 0; i < 2; i++) begin
            exec(i ? 32'hEFFF_FFFF : 32'hEF00_0000, 1'b1);
            chk(pc_v, STCE_VEC_SVC);
            chk(st_v[4:0], STCE_MODE_SVC32);
            apb(1'b0, STCE_OFS_SVC_LINK);
            chk(rd, 32'h0000_0204);
            apb(1'b0, STCE_OFS_SVC_SAVED);
            chk(rd, 32'hA000_0010);
        end
        // flag-setting return
        cur_status <= 32'h6000_0013;
        exec(32'hE1B0_F00E, 1'b1);
        chk(pc_v, 32'h0000_0204);
        chk(st_v, 32'hA000_0010);
        // cp ops to two numbers, one other form
        for (int i = 0; i < 3; i++) begin
            exec(cp_w[i], 1'b1);
            chk(got_cp, cp_n[i]);
            chk(cp_v, cp_n[i] ? cp_w[i] : 32'h0000_0000);
        end
        chk(hits4 * 16 + hits5, 17);
        chk(dest4, 4'h3);
        print_verdict();
    end
endmodule : stce_exec_tb

bind stce_exec stce_monitor i_mon (.*);
